// ===== design/bcfi_pkg.sv
package bcfi_pkg;

  // frame geometry
  localparam int unsigned CORE_LEN    = 7;    // command, type, selector, four value bytes
  localparam int unsigned SER_LEN     = 9;    // address + core + checksum
  localparam logic [3:0]  CNT_RST     = 4'h0; // byte counter after reset

  // status codes placed in the reply
  localparam logic [7:0] ST_OK        = 8'h64; // 100: executed
  localparam logic [7:0] ST_STORED    = 8'h65; // 101: loaded into program memory
  localparam logic [7:0] ST_CHKSUM    = 8'h01;
  localparam logic [7:0] ST_BAD_CMD   = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED    = 8'h05;
  localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

  // inter-byte timeout
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned GAP_TIMEOUT_US = 200;
  localparam int unsigned GAP_CYCLES    = (GAP_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam logic [11:0] GAP_LIMIT     = 12'(GAP_CYCLES);
  localparam logic [11:0] GAP_RST       = 12'h000;

  // program memory
  localparam int unsigned PROG_DEPTH  = 16;
  localparam logic [3:0]  PTR_RST     = 4'h0;

  // decoded seven-byte core command
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  kind;
    logic [7:0]  sel;
    logic [31:0] value;
  } bcfi_cmd_type;

  // command handed to the executor
  typedef struct packed {
    logic         valid;
    bcfi_cmd_type cmd;
  } bcfi_exec_req_type;

  // executor answer
  typedef struct packed {
    logic        done;
    logic [7:0]  status;
    logic [31:0] value;
  } bcfi_exec_rsp_type;

  // one byte on a link
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bcfi_byte_type;

  typedef enum logic [2:0] {
    S_RECV,
    S_EXEC,
    S_STORE,
    S_SEND,
    S_RUN
  } bcfi_state_type;

endpackage : bcfi_pkg

// ===== design/bcfi_top.sv
`timescale 1ns/1ps
`default_nettype none

module bcfi_top (
  input  wire logic                       core_clk_in,   // 10 mhz system clock
  input  wire logic                       rst_in,        // synchronous, active high
  input  wire logic                       can_mode_in,   // 1: can framing, 0: serial/usb framing
  input  wire logic [7:0]                 module_addr_in,// own address on serial links
  input  wire logic [7:0]                 reply_addr_in, // host address placed first in serial replies
  input  wire logic                       download_in,   // commands are stored, not executed
  input  wire logic                       run_in,        // pulse: start stored program
  input  wire bcfi_pkg::bcfi_byte_type    rx_in,         // received byte stream
  input  wire logic                       tx_ready_in,   // link can take a reply byte
  input  wire bcfi_pkg::bcfi_exec_rsp_type exec_rsp_in,  // executor answer
  output logic                            tx_valid_out,  // reply byte present
  output logic [7:0]                      tx_data_out,   // reply byte
  output logic                            tx_last_out,   // final reply byte
  output bcfi_pkg::bcfi_exec_req_type     exec_req_out,  // command to execute
  output logic                            running_out,   // standalone program active
  output logic [3:0]                      prog_len_out   // commands held in program memory
);

  // sum of bytes modulo 256, used on receive and transmit
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    add8 = 8'(a + b);
  endfunction : add8

  // all state of the block except the program memory
  typedef struct packed {
    bcfi_pkg::bcfi_state_type state;
    logic [3:0]               rx_cnt;   // bytes of frame taken so far
    logic [7:0]               rx_sum;   // running checksum
    logic [71:0]              rx_buf;   // bytes shifted in
    logic                     for_me;   // address byte matched
    logic [11:0]              gap;      // cycles since last byte
    bcfi_pkg::bcfi_cmd_type   cmd;      // latched command
    logic [7:0]               status;   // reply status
    logic [31:0]              rvalue;   // reply value
    logic [71:0]              tx_buf;   // reply frame
    logic [3:0]               tx_cnt;   // reply bytes left
    logic [7:0]               tx_sum;   // reply checksum accumulator
    logic                     req;      // executor request pending
    logic [3:0]               wr_ptr;   // program length
    logic [3:0]               rd_ptr;   // standalone fetch pointer
    logic                     busy;     // standalone command in flight
  } bcfi_state_r_type;

  bcfi_state_r_type st_r;
  bcfi_state_r_type st_nxt;

  // program memory; a handful of commands is enough for this block
  bcfi_pkg::bcfi_cmd_type prog_mem [bcfi_pkg::PROG_DEPTH];
  logic                   prog_we;

  logic [3:0]             frame_len;  // length of the current frame format
  logic [55:0]            core_bytes; // received core, oldest byte highest
  logic [7:0]             rx_chk;     // checksum byte as received

  // framing selection: can drops address and checksum
  always_comb begin
    frame_len  = can_mode_in ? 4'(bcfi_pkg::CORE_LEN) : 4'(bcfi_pkg::SER_LEN);
    rx_chk     = st_r.rx_buf[7:0];
    core_bytes = can_mode_in ? st_r.rx_buf[55:0] : st_r.rx_buf[63:8];
  end

  // next-state logic for the whole interpreter
  always_comb begin
    st_nxt  = st_r;
    prog_we = 1'b0;
    unique case (st_r.state)
      bcfi_pkg::S_RECV: begin
        // timeout on a partial frame: drop and wait for a fresh first byte
        if (rx_in.valid) begin
          st_nxt.gap = bcfi_pkg::GAP_RST;
        end else if (st_r.rx_cnt != bcfi_pkg::CNT_RST) begin
          st_nxt.gap = 12'(st_r.gap + 12'h001);
          if (st_r.gap >= bcfi_pkg::GAP_LIMIT) begin
            st_nxt.rx_cnt = bcfi_pkg::CNT_RST;
            st_nxt.rx_sum = 8'h00;
            st_nxt.gap    = bcfi_pkg::GAP_RST;
          end
        end
        if (rx_in.valid) begin
          st_nxt.rx_buf = {st_r.rx_buf[63:0], rx_in.data};
          st_nxt.rx_sum = add8(st_r.rx_sum, rx_in.data);
          st_nxt.rx_cnt = 4'(st_r.rx_cnt + 4'h1);
          if (st_r.rx_cnt == bcfi_pkg::CNT_RST) begin
            st_nxt.for_me = can_mode_in || (rx_in.data == module_addr_in);
          end
        end
        // complete frame
        if (st_r.rx_cnt == frame_len) begin
          st_nxt.rx_cnt = bcfi_pkg::CNT_RST;
          st_nxt.rx_sum = 8'h00;
          st_nxt.cmd    = core_bytes;
          if (!st_r.for_me) begin
            st_nxt.state = bcfi_pkg::S_RECV; // other module's frame: stay silent
          end else if (!can_mode_in && (add8(st_r.rx_sum, 8'(~rx_chk + 8'h01)) != rx_chk)) begin
            // sum of the first eight bytes equals rx_sum minus the checksum byte
            st_nxt.status = bcfi_pkg::ST_CHKSUM;
            st_nxt.rvalue = core_bytes[31:0];
            st_nxt.state  = bcfi_pkg::S_SEND;
          end else if (download_in) begin
            st_nxt.state = bcfi_pkg::S_STORE;
          end else begin
            st_nxt.req   = 1'b1;
            st_nxt.state = bcfi_pkg::S_EXEC;
          end
        end
        // start a stored program when idle
        if (run_in && st_r.rx_cnt == bcfi_pkg::CNT_RST && !rx_in.valid && st_r.wr_ptr != bcfi_pkg::PTR_RST) begin
          st_nxt.rd_ptr = bcfi_pkg::PTR_RST;
          st_nxt.state  = bcfi_pkg::S_RUN;
        end
      end
      bcfi_pkg::S_STORE: begin
        prog_we       = (st_r.wr_ptr != 4'hf);
        st_nxt.wr_ptr = prog_we ? 4'(st_r.wr_ptr + 4'h1) : st_r.wr_ptr;
        st_nxt.status = bcfi_pkg::ST_STORED;
        st_nxt.rvalue = st_r.cmd.value;
        st_nxt.state  = bcfi_pkg::S_SEND;
      end
      bcfi_pkg::S_EXEC: begin
        st_nxt.req = 1'b0;
        // reply waits for the executor to finish the command
        if (exec_rsp_in.done) begin
          st_nxt.status = exec_rsp_in.status; // executor gives 100 or 2..6
          st_nxt.rvalue = exec_rsp_in.value;
          st_nxt.state  = bcfi_pkg::S_SEND;
        end
      end
      bcfi_pkg::S_RUN: begin
        // standalone: feed stored commands, no reply is sent
        // busy holds the next fetch back until done; a bare req flag would refire every other cycle
        st_nxt.req = 1'b0;
        if (!st_r.busy) begin
          st_nxt.cmd  = prog_mem[st_r.rd_ptr];
          st_nxt.req  = 1'b1;
          st_nxt.busy = 1'b1;
        end else if (exec_rsp_in.done && !st_r.req) begin
          st_nxt.busy   = 1'b0;
          st_nxt.rd_ptr = 4'(st_r.rd_ptr + 4'h1);
          if (4'(st_r.rd_ptr + 4'h1) == st_r.wr_ptr) begin
            st_nxt.state = bcfi_pkg::S_RECV;
          end
        end
      end
      bcfi_pkg::S_SEND: begin
        if (st_r.tx_cnt == 4'h0) begin
          // build reply frame once, oldest byte highest
          st_nxt.tx_buf = {reply_addr_in, module_addr_in, st_r.status, st_r.cmd.code, st_r.rvalue, 8'h00};
          st_nxt.tx_cnt = frame_len;
          st_nxt.tx_sum = 8'h00;
          if (can_mode_in) begin
            st_nxt.tx_buf = {st_r.status, st_r.cmd.code, st_r.rvalue, 24'h000000}; // pad byte then fill
          end
        end else if (tx_ready_in) begin
          st_nxt.tx_buf = {st_r.tx_buf[63:0], 8'h00};
          st_nxt.tx_sum = add8(st_r.tx_sum, st_r.tx_buf[71:64]);
          st_nxt.tx_cnt = 4'(st_r.tx_cnt - 4'h1);
          if (st_r.tx_cnt == 4'h1) begin
            st_nxt.state = bcfi_pkg::S_RECV;
          end
        end
      end
      default: st_nxt.state = bcfi_pkg::S_RECV;
    endcase
  end

  // register the state
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r        <= '0;
      st_r.state  <= bcfi_pkg::S_RECV;
      st_r.rx_cnt <= bcfi_pkg::CNT_RST;
      st_r.gap    <= bcfi_pkg::GAP_RST;
      st_r.wr_ptr <= bcfi_pkg::PTR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // program store write port
  always_ff @(posedge core_clk_in) begin
    if (prog_we) begin
      prog_mem[st_r.wr_ptr] <= st_r.cmd;
    end
  end

  // reply byte drive; checksum substitutes the last serial byte
  always_comb begin
    tx_valid_out = (st_r.state == bcfi_pkg::S_SEND) && (st_r.tx_cnt != 4'h0);
    tx_last_out  = tx_valid_out && (st_r.tx_cnt == 4'h1);
    tx_data_out  = st_r.tx_buf[71:64];
    if (tx_last_out && !can_mode_in) begin
      tx_data_out = st_r.tx_sum;
    end
    exec_req_out.valid = st_r.req;
    exec_req_out.cmd   = st_r.cmd;
    running_out        = (st_r.state == bcfi_pkg::S_RUN);
    prog_len_out       = st_r.wr_ptr;
  end

  // a reply byte only goes out while sending
  a_tx_only_send: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tx_valid_out |-> st_r.state == bcfi_pkg::S_SEND)
    else $error("reply byte outside send state");

  // downloaded commands answer 101
  a_store_status: assert property (@(posedge core_clk_in) disable iff (rst_in)
    st_r.state == bcfi_pkg::S_STORE |=> st_r.status == bcfi_pkg::ST_STORED)
    else $error("stored command without status 101");

  // serial reply has nine bytes
  a_serial_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_SEND && st_r.tx_cnt == 4'h0 && !can_mode_in) |=> st_r.tx_cnt == 4'h9)
    else $error("serial reply length wrong");

  // can reply has seven bytes
  a_can_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_SEND && st_r.tx_cnt == 4'h0 && can_mode_in) |=> st_r.tx_cnt == 4'h7)
    else $error("can reply length wrong");

  // last serial byte is the sum of the eight before it
  a_reply_sum: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (tx_last_out && !can_mode_in) |-> tx_data_out == st_r.tx_sum)
    else $error("reply checksum wrong");

  // reply only after executor done
  a_exec_wait: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_EXEC && !exec_rsp_in.done) |=> st_r.state == bcfi_pkg::S_EXEC)
    else $error("left execute before done");

  // a bad serial checksum goes straight to an error reply
  a_bad_sum: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_RECV && st_nxt.state == bcfi_pkg::S_SEND) |=> st_r.status == bcfi_pkg::ST_CHKSUM)
    else $error("checksum error status missing");

  // stalled partial frame is dropped
  a_gap_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_RECV && st_r.gap >= bcfi_pkg::GAP_LIMIT && !rx_in.valid
     && st_r.rx_cnt != frame_len && !run_in) |=> st_r.rx_cnt == bcfi_pkg::CNT_RST)
    else $error("partial frame not discarded");

  // a standalone request is a single pulse, low again in the cycle after it is raised
  a_run_one_req: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_RUN && st_r.req) |=> !st_r.req)
    else $error("standalone request held or repeated");

  // every executor request is one cycle long
  a_req_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
    exec_req_out.valid |=> !exec_req_out.valid)
    else $error("executor request longer than one cycle");

  // executor status reaches the reply unchanged
  a_exec_status: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_EXEC && exec_rsp_in.done) |=> st_r.status == $past(exec_rsp_in.status))
    else $error("executor status lost");

  // can frames are never refused for a checksum
  a_can_no_sum: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_RECV && can_mode_in && st_r.rx_cnt == frame_len) |=> st_r.state != bcfi_pkg::S_SEND)
    else $error("can frame given a checksum error");

  // a frame for another module leaves the receiver idle and silent
  a_addr_silent: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r.state == bcfi_pkg::S_RECV && st_r.rx_cnt == frame_len && !st_r.for_me) |=> st_r.state == bcfi_pkg::S_RECV)
    else $error("reply to a frame for another module");

  // a serial reply opens with the host address
  a_reply_lead: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (tx_valid_out && !can_mode_in && st_r.tx_cnt == 4'h9) |-> tx_data_out == reply_addr_in)
    else $error("serial reply does not start with host address");

  // a can reply opens with the status byte
  a_can_lead: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (tx_valid_out && can_mode_in && st_r.tx_cnt == 4'h7) |-> tx_data_out == st_r.status)
    else $error("can reply does not start with status");

  // the gap counter never runs past its limit, so the drop cannot be skipped
  a_gap_bound: assert property (@(posedge core_clk_in) disable iff (rst_in)
    st_r.gap <= bcfi_pkg::GAP_LIMIT)
    else $error("gap counter beyond limit");

endmodule : bcfi_top

`default_nettype wire

// ===== test/bcfi_exec_model.sv
`timescale 1ns/1ps
`default_nettype none

// executor stand-in: answers each request after a bench-chosen delay
module bcfi_exec_model (
  input  wire logic                         clk_in,    // system clock
  input  wire logic                         rst_in,    // synchronous, active high
  input  wire bcfi_pkg::bcfi_exec_req_type  req_in,    // request from the interpreter
  input  wire logic [3:0]                   delay_in,  // cycles of work before done
  input  wire logic [7:0]                   status_in, // status to report
  input  wire logic [31:0]                  value_in,  // value to report
  output var  bcfi_pkg::bcfi_exec_rsp_type  rsp_out    // answer to the interpreter
);
  logic [3:0] cnt_r;  // remaining work cycles
  logic       busy_r; // a request is being worked on
  logic       done_w; // work finished this cycle

  // count down the work; done only once the work has ended
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (req_in.valid) begin
      busy_r <= 1'b1;
      cnt_r  <= delay_in;
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  // outside the done cycle status and value are scrambled, so stale data never looks valid
  assign done_w  = busy_r && (cnt_r == 4'h0);
  assign rsp_out = {done_w, done_w ? status_in : ~status_in, done_w ? value_in : ~value_in};
endmodule : bcfi_exec_model

`default_nettype wire

// ===== test/bcfi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bcfi_top_tb;
  logic                        core_clk_in, rst_in, can_mode_in, download_in, run_in, tx_ready_in;
  logic [7:0]                  module_addr_in, reply_addr_in, tx_data_out, p_status;
  logic                        tx_valid_out, tx_last_out, running_out, seen_tx;
  logic [3:0]                  prog_len_out, p_delay;
  logic [31:0]                 p_value;
  bcfi_pkg::bcfi_byte_type     rx_in;
  bcfi_pkg::bcfi_exec_rsp_type exec_rsp_in;
  bcfi_pkg::bcfi_exec_req_type exec_req_out;
  bcfi_pkg::bcfi_cmd_type      last_cmd, c, st_q[3];
  int                          seed = 32'h684f;
  int                          mismatches = 0, n_compared = 0, n_req = 0, nr, t;

  bcfi_top i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .can_mode_in(can_mode_in),
    .module_addr_in(module_addr_in), .reply_addr_in(reply_addr_in), .download_in(download_in),
    .run_in(run_in), .rx_in(rx_in), .tx_ready_in(tx_ready_in), .exec_rsp_in(exec_rsp_in),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
    .exec_req_out(exec_req_out), .running_out(running_out), .prog_len_out(prog_len_out));
  bcfi_exec_model i_exec (.clk_in(core_clk_in), .rst_in(rst_in), .req_in(exec_req_out),
    .delay_in(p_delay), .status_in(p_status), .value_in(p_value), .rsp_out(exec_rsp_in));

  // 10 mhz clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // log every executor request mid-cycle, clear of the edge that launches it
  always @(negedge core_clk_in) begin
    if (exec_req_out.valid === 1'b1) begin
      n_req    <= n_req + 1;
      last_cmd <= exec_req_out.cmd;
    end
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_cmd(input bcfi_pkg::bcfi_cmd_type got, input bcfi_pkg::bcfi_cmd_type exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t command got %h expected %h", $time, got, exp);
    end
  endtask : cmp_cmd

  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  // send a frame, cut short after lim bytes; cs_err spoils the checksum
  task automatic send_frame(input bcfi_pkg::bcfi_cmd_type cm, input logic [7:0] addr, input int lim,
                            input logic [7:0] cs_err);
    logic [7:0]  b [9];
    logic [55:0] v;
    logic [7:0]  s;
    v    = cm;
    s    = addr;
    b[0] = addr;
    for (int k = 0; k < 7; k++) begin
      b[k+1] = v[55-8*k -: 8];
      s      = s + b[k+1];
    end
    b[8] = s + cs_err;
    for (int k = 0; k < (can_mode_in ? 7 : 9) && k < lim; k++) begin
      rx_in = '{1'b1, can_mode_in ? b[k+1] : b[k]};
      tick(1);
    end
    // idle data gets a fresh random value after each frame so it is never mistaken for a held byte
    rx_in = '{1'b0, 8'($random(seed))};
  endtask : send_frame

  // collect a reply while stalling the link at random
  task automatic check_reply(input logic [7:0] st, input logic [7:0] code, input logic [31:0] val);
    logic [7:0] e [9];
    logic [7:0] s;
    int         n, i, w;
    n = can_mode_in ? 7 : 9;
    e = '{reply_addr_in, module_addr_in, st, code, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    s = 8'h00;
    for (int k = 0; k < 8; k++) s = s + e[k];
    e[8] = s;
    if (can_mode_in) e = '{st, code, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00, 8'h00, 8'h00};
    i = 0;
    w = 0;
    while (i < n && w < 300) begin
      tx_ready_in = ($random(seed) & 3) != 0;
      // look mid-cycle: a byte with valid and ready leaves at the next rising edge
      @(negedge core_clk_in);
      if (tx_valid_out === 1'b1 && tx_ready_in) begin
        cmp_byte(tx_data_out, e[i]);
        cmp_byte({7'h0, tx_last_out}, {7'h0, i == n - 1});
        i++;
      end
      w++;
      tick(1);
    end
    tx_ready_in = 1'b0;
    cmp_byte(8'(i), 8'(n));
  endtask : check_reply

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #2_000_000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    {can_mode_in, download_in, run_in, tx_ready_in, p_delay} = '0;
    module_addr_in = 8'($random(seed));
    reply_addr_in  = 8'($random(seed));
    rx_in          = '{1'b0, 8'h00};
    p_status       = bcfi_pkg::ST_OK;
    p_value        = '0;
    rst_in         = 1'b1;
    tick(6);
    rst_in = 1'b0;
    cmp_byte({4'h0, prog_len_out}, 8'h00);
    // random commands on both framings, success then every executor error
    for (int r = 0; r < 12; r++) begin
      can_mode_in = r[0];
      c           = 56'({$random(seed), $random(seed)});
      p_delay     = r < 7 ? 4'hf : 4'h0;
      p_status    = r < 7 ? bcfi_pkg::ST_OK : 8'(r - 5);
      p_value     = $random(seed);
      send_frame(c, module_addr_in, 9, 8'h00);
      tick(8);
      if (r < 7) cmp_byte({7'h0, tx_valid_out}, 8'h00);
      cmp_cmd(last_cmd, c);
      check_reply(p_status, c.code, p_value);
    end
    $display("test commands done");
    // spoiled checksum is refused without execution; wrong address gets silence
    can_mode_in = 1'b0;
    nr          = n_req;
    c           = 56'({$random(seed), $random(seed)});
    send_frame(c, module_addr_in, 9, 8'h5a);
    check_reply(bcfi_pkg::ST_CHKSUM, c.code, c.value);
    send_frame(c, module_addr_in ^ 8'h01, 9, 8'h00);
    tick(40);
    cmp_byte({7'h0, tx_valid_out}, 8'h00);
    cmp_byte(8'(n_req - nr), 8'h00);
    $display("test refusals done");
    // a stalled partial frame is dropped, the next frame is served
    send_frame(c, module_addr_in, 4, 8'h00);
    tick(2010);
    p_status = bcfi_pkg::ST_OK;
    send_frame(c, module_addr_in, 9, 8'h00);
    check_reply(bcfi_pkg::ST_OK, c.code, p_value);
    $display("test gap done");
    // download three commands, then run them standalone without replies
    download_in = 1'b1;
    nr          = n_req;
    for (int k = 0; k < 3; k++) begin
      st_q[k] = 56'({$random(seed), $random(seed)});
      send_frame(st_q[k], module_addr_in, 9, 8'h00);
      check_reply(bcfi_pkg::ST_STORED, st_q[k].code, st_q[k].value);
    end
    download_in = 1'b0;
    cmp_byte({4'h0, prog_len_out}, 8'h03);
    cmp_byte(8'(n_req - nr), 8'h00);
    p_delay = 4'h2;
    seen_tx = 1'b0;
    run_in  = 1'b1;
    tick(1);
    run_in = 1'b0;
    tick(1);
    cmp_byte({7'h0, running_out}, 8'h01);
    for (t = 0; t < 300 && n_req - nr < 3; t++) begin
      seen_tx = seen_tx | (tx_valid_out === 1'b1);
      tick(1);
    end
    tick(20);
    cmp_byte(8'(n_req - nr), 8'h03);
    cmp_cmd(last_cmd, st_q[2]);
    cmp_byte({7'h0, seen_tx | tx_valid_out}, 8'h00);
    cmp_byte({7'h0, running_out}, 8'h00);
    $display("test standalone done");
    stop_test();
  end
endmodule : bcfi_top_tb

`default_nettype wire
